// [src/lookup_learning_aging_flush_ctrl.sv]
// Behaviour
// - learning-off bit stops unicast learning
// - self filter drops frames matching switch MAC
// - self filter needs global and port enable
// - table flush bit starts flush, self clears
// - flush scope limits entries; static ones only with scope static or both
// - spanning-tree flush bit removes matched entries
// - multicast-source bit forwards or drops frames
// - aging bit enables or suspends aging
// - fast-aging bit selects faster rate
// - link-down flush clears entries of dropped port
// - scope codes none, dynamic, static, both
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module lookup_learning_aging_flush_ctrl
#(
  parameter int NUM_PORTS = 7
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb register port
  input wire lookup_ctrl_pkg::apb_req_t apbReq,
  output lookup_ctrl_pkg::apb_rsp_t apbRsp,
  // switch context
  input wire logic [47:0] switchMac,
  input wire logic [NUM_PORTS-1:0] portSelfFiltEn,
  input wire logic [NUM_PORTS-1:0] portLinkUp,
  // received frame check
  input wire lookup_ctrl_pkg::rx_frame_t rxFrame,
  output logic frameDrop,
  output logic learnAllow,
  // aging controls
  output logic agingEnable,
  output logic fastAging,
  // flush walker handshake
  output lookup_ctrl_pkg::flush_cmd_t flushCmd,
  input wire logic flushDone
);
  import lookup_ctrl_pkg::*;

  // port mask is eight wide and the frame port field addresses eight ports, more ports cannot be served
  if (NUM_PORTS < 1 || NUM_PORTS > 8)
  begin : gPortCheck
    $error("NUM_PORTS must be 1 to 8");
  end

  // ==========================================================================
  // register state
  logic learnOff_q;
  logic selfFilt_q;
  logic mcastFwd_q;
  logic agingOn_q;
  logic fastAging_q;
  logic linkFlush_q;
  logic [1:0] scope_q;
  logic tableReq_q;
  logic mstpReq_q;
  logic [NUM_PORTS-1:0] linkPend_q;
  logic [NUM_PORTS-1:0] linkPrev_q;
  logic [NUM_PORTS-1:0] curMask_q;
  flush_state_t state_q;
  logic [7:0] ctrlRead;
  logic wrAccess;
  logic [NUM_PORTS-1:0] linkFall;
  logic [7:0] filtEnAll;

  assign wrAccess = apbReq.psel && apbReq.penable && apbReq.pwrite;
  // padded to the port field's range, absent ports never filter
  assign filtEnAll = 8'(portSelfFiltEn);
  assign linkFall = linkPrev_q & ~portLinkUp;

  // plain control bits, written only in the access phase
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      learnOff_q <= CTRL1_RESET[LEARN_OFF_BIT];
      selfFilt_q <= CTRL1_RESET[SELF_FILT_BIT];
      mcastFwd_q <= CTRL1_RESET[MCAST_SRC_FWD_BIT];
      agingOn_q <= CTRL1_RESET[AGING_ON_BIT];
      fastAging_q <= CTRL1_RESET[FAST_AGING_BIT];
      linkFlush_q <= CTRL1_RESET[LINK_FLUSH_BIT];
      scope_q <= SCOPE_NONE;
    end
    else if (wrAccess && apbReq.paddr == CTRL1_ADDR)
    begin
      learnOff_q <= apbReq.pwdata[LEARN_OFF_BIT];
      selfFilt_q <= apbReq.pwdata[SELF_FILT_BIT];
      mcastFwd_q <= apbReq.pwdata[MCAST_SRC_FWD_BIT];
      agingOn_q <= apbReq.pwdata[AGING_ON_BIT];
      fastAging_q <= apbReq.pwdata[FAST_AGING_BIT];
      linkFlush_q <= apbReq.pwdata[LINK_FLUSH_BIT];
    end
    else if (wrAccess && apbReq.paddr == SCOPE_ADDR)
    begin
      scope_q <= apbReq.pwdata[1:0];
    end
  end

  // ==========================================================================
  // self-clearing flush requests; a write of one sets, completion clears
  // set is checked after clear so a new request is never lost
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tableReq_q <= 1'b0;
      mstpReq_q <= 1'b0;
    end
    else
    begin
      if (state_q == FL_TABLE && flushDone)
        tableReq_q <= 1'b0;
      if (state_q == FL_MSTP && flushDone)
        mstpReq_q <= 1'b0;
      if (wrAccess && apbReq.paddr == CTRL1_ADDR && apbReq.pwdata[TABLE_FLUSH_BIT])
        tableReq_q <= 1'b1;
      if (wrAccess && apbReq.paddr == CTRL1_ADDR && apbReq.pwdata[MSTP_FLUSH_BIT])
        mstpReq_q <= 1'b1;
    end
  end

  // link-down edges queue per port flushes while enabled
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      linkPrev_q <= '0;
      linkPend_q <= '0;
    end
    else
    begin
      linkPrev_q <= portLinkUp;
      if (state_q == FL_LINK && flushDone)
        linkPend_q <= (linkPend_q & ~curMask_q) | (linkFlush_q ? linkFall : '0);
      else if (linkFlush_q)
        linkPend_q <= linkPend_q | linkFall;
      else
        linkPend_q <= '0;
    end
  end

  // ==========================================================================
  // flush sequencer: one walk at a time, table then mstp then link
  // a scope of none never starts the walker, yet the sequencer still waits for flushDone
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= FL_IDLE;
      flushCmd <= '0;
      curMask_q <= '0;
    end
    else
    begin
      flushCmd.start <= 1'b0;
      unique case (state_q)
        FL_IDLE:
        begin
          flushCmd.flushDynamic <= scope_q[0];
          flushCmd.flushStatic <= scope_q[1];
          if (tableReq_q || mstpReq_q || (|linkPend_q))
          begin
            flushCmd.start <= (scope_q != SCOPE_NONE);
            flushCmd.mstpOnly <= !tableReq_q && mstpReq_q;
            if (tableReq_q)
            begin
              state_q <= FL_TABLE;
              flushCmd.portMask <= 8'hFF;
            end
            else if (mstpReq_q)
            begin
              state_q <= FL_MSTP;
              flushCmd.portMask <= 8'hFF;
            end
            else
            begin
              state_q <= FL_LINK;
              curMask_q <= linkPend_q;
              flushCmd.portMask <= 8'(linkPend_q);
            end
          end
        end
        FL_TABLE, FL_MSTP, FL_LINK:
        begin
          if (flushDone)
            state_q <= FL_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // frame checks and engine controls, all registered
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      frameDrop <= 1'b0;
      learnAllow <= 1'b0;
      agingEnable <= 1'b0;
      fastAging <= 1'b0;
    end
    else
    begin
      frameDrop <= rxFrame.valid && (
        (selfFilt_q && filtEnAll[rxFrame.port]
         && rxFrame.srcAddr == switchMac)
        || (!mcastFwd_q && rxFrame.srcAddr[40]));
      learnAllow <= !learnOff_q && !rxFrame.srcAddr[40];
      agingEnable <= agingOn_q;
      fastAging <= fastAging_q;
    end
  end

  // ==========================================================================
  // apb slave: zero wait states, unmapped reads zero with error
  always_comb
  begin
    ctrlRead = '0;
    ctrlRead[LEARN_OFF_BIT] = learnOff_q;
    ctrlRead[SELF_FILT_BIT] = selfFilt_q;
    ctrlRead[TABLE_FLUSH_BIT] = tableReq_q;
    ctrlRead[MSTP_FLUSH_BIT] = mstpReq_q;
    ctrlRead[MCAST_SRC_FWD_BIT] = mcastFwd_q;
    ctrlRead[AGING_ON_BIT] = agingOn_q;
    ctrlRead[FAST_AGING_BIT] = fastAging_q;
    ctrlRead[LINK_FLUSH_BIT] = linkFlush_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      apbRsp <= '0;
    end
    else
    begin
      apbRsp.pready <= apbReq.psel && !apbReq.penable;
      apbRsp.pslverr <= apbReq.psel && !apbReq.penable && apbReq.paddr != CTRL1_ADDR
        && apbReq.paddr != SCOPE_ADDR && apbReq.paddr != STATUS_ADDR;
      if (apbReq.psel && !apbReq.penable && !apbReq.pwrite)
      begin
        unique case (apbReq.paddr)
          CTRL1_ADDR: apbRsp.prdata <= {24'h000000, ctrlRead};
          SCOPE_ADDR: apbRsp.prdata <= {30'h00000000, scope_q};
          STATUS_ADDR: apbRsp.prdata <= {24'h000000, 8'(linkPend_q)};
          default: apbRsp.prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // lookup_learning_aging_flush_ctrl

// [src/lookup_ctrl_pkg.sv]
package lookup_ctrl_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] CTRL1_OFFSET = 12'h311; // printed register index
  localparam logic [31:0] CTRL1_ADDR = 32'h00000C44; // index times four
  localparam logic [31:0] SCOPE_ADDR = 32'h00000C48; // flush scope register
  localparam logic [31:0] STATUS_ADDR = 32'h00000C4C; // engine status register

  // ==========================================================================
  // field positions in the control register
  localparam int LEARN_OFF_BIT = 7;
  localparam int SELF_FILT_BIT = 6;
  localparam int TABLE_FLUSH_BIT = 5;
  localparam int MSTP_FLUSH_BIT = 4;
  localparam int MCAST_SRC_FWD_BIT = 3;
  localparam int AGING_ON_BIT = 2;
  localparam int FAST_AGING_BIT = 1;
  localparam int LINK_FLUSH_BIT = 0;
  localparam logic [7:0] CTRL1_RESET = 8'h0C;

  // flush scope encoding
  localparam logic [1:0] SCOPE_NONE = 2'h0;
  localparam logic [1:0] SCOPE_DYNAMIC = 2'h1;
  localparam logic [1:0] SCOPE_STATIC = 2'h2;
  localparam logic [1:0] SCOPE_BOTH = 2'h3;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // one received frame presented for source-address checks
  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic [47:0] srcAddr;
  } rx_frame_t;

  // flush command to the lookup table walker
  typedef struct packed {
    logic start;
    logic mstpOnly;
    logic flushDynamic;
    logic flushStatic;
    logic [7:0] portMask;
  } flush_cmd_t;

  typedef enum {FL_IDLE, FL_TABLE, FL_MSTP, FL_LINK} flush_state_t;

endpackage

// [tb/lookup_ctrl_chk.sv]
`timescale 1ns/1ps
// ====================
// port checks
module lookup_ctrl_chk
#(
  parameter int NUM_PORTS = 7
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // watched ports
  input wire lookup_ctrl_pkg::apb_req_t apbReq,
  input wire lookup_ctrl_pkg::apb_rsp_t apbRsp,
  input wire logic [47:0] switchMac,
  input wire logic [NUM_PORTS-1:0] portSelfFiltEn,
  input wire lookup_ctrl_pkg::rx_frame_t rxFrame,
  input wire logic frameDrop,
  input wire logic learnAllow,
  input wire logic agingEnable,
  input wire logic fastAging,
  input wire lookup_ctrl_pkg::flush_cmd_t flushCmd
);
  import lookup_ctrl_pkg::*;
  logic [7:0] ctrl_q;
  logic [1:0] scope_q;
  logic rstDly_q;
  logic wrEn;
  logic learnExp;
  logic dropExp;
  logic [7:0] filtEn;
  // shadow of software settings, taken at the access edge
  assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
  assign filtEn = 8'(portSelfFiltEn);
  assign learnExp = !ctrl_q[LEARN_OFF_BIT] && !rxFrame.srcAddr[40];
  assign dropExp = rxFrame.valid && ((ctrl_q[SELF_FILT_BIT] && filtEn[rxFrame.port]
    && rxFrame.srcAddr == switchMac) || (!ctrl_q[MCAST_SRC_FWD_BIT] && rxFrame.srcAddr[40]));
  always_ff @(posedge sys_clk)
  begin
    rstDly_q <= rst;
    if (rst)
    begin
      ctrl_q <= CTRL1_RESET;
      scope_q <= SCOPE_NONE;
    end
    else if (wrEn && apbReq.paddr == CTRL1_ADDR)
      ctrl_q <= apbReq.pwdata[7:0];
    else if (wrEn && apbReq.paddr == SCOPE_ADDR)
      scope_q <= apbReq.pwdata[1:0];
  end
  // outputs settle one edge after reset, so that edge is skipped
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst || rstDly_q);
  sequence flushWr;
    wrEn && apbReq.paddr == CTRL1_ADDR && apbReq.pwdata[TABLE_FLUSH_BIT] && scope_q != SCOPE_NONE;
  endsequence
  AST_READY: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("no ready after setup");
  // read data only means something on reads, a refused write leaves it alone
  AST_ERR: assert property (apbRsp.pslverr |-> apbRsp.pready && (apbReq.pwrite || apbRsp.prdata == 32'h0))
    else $error("bad error response");
  AST_LEARN: assert property (learnAllow == $past(learnExp))
    else $error("learn enable wrong");
  AST_DROP: assert property (frameDrop == $past(dropExp))
    else $error("drop decision wrong");
  AST_AGE: assert property (agingEnable == $past(ctrl_q[AGING_ON_BIT]))
    else $error("aging enable wrong");
  AST_FAST: assert property (fastAging == $past(ctrl_q[FAST_AGING_BIT]))
    else $error("fast aging wrong");
  AST_START: assert property (flushWr |-> ##[2:3] flushCmd.start)
    else $error("flush not started");
  AST_PULSE: assert property (flushCmd.start |=> !flushCmd.start)
    else $error("start too long");
  AST_SCOPE: assert property (flushCmd.start |-> {flushCmd.flushStatic, flushCmd.flushDynamic} == scope_q)
    else $error("flush scope wrong");
endmodule // lookup_ctrl_chk

bind lookup_learning_aging_flush_ctrl lookup_ctrl_chk #(.NUM_PORTS(NUM_PORTS)) lookup_ctrl_chk_inst (
  .sys_clk(sys_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .switchMac(switchMac),
  .portSelfFiltEn(portSelfFiltEn), .rxFrame(rxFrame), .frameDrop(frameDrop), .learnAllow(learnAllow),
  .agingEnable(agingEnable), .fastAging(fastAging), .flushCmd(flushCmd));

// [tb/lookup_learning_aging_flush_ctrl_test.sv]
`timescale 1ns/1ps
// ====================
// bench
module lookup_learning_aging_flush_ctrl_test;
  import lookup_ctrl_pkg::*;
  localparam logic [47:0] MAC = 48'h0200000000AB; // arbitrary unicast address
  logic sys_clk;
  logic rst;
  apb_req_t req;
  apb_rsp_t rsp;
  rx_frame_t rx;
  flush_cmd_t cmd;
  logic [6:0] en;
  logic [6:0] link;
  logic drop, learn, age, fast, fd, err;
  logic [31:0] r;
  int failures;
  int totalChecks;
  lookup_learning_aging_flush_ctrl #(.NUM_PORTS(7)) lookup_learning_aging_flush_ctrl_inst (
    .sys_clk(sys_clk), .rst(rst), .apbReq(req), .apbRsp(rsp), .switchMac(MAC), .portSelfFiltEn(en),
    .portLinkUp(link), .rxFrame(rx), .frameDrop(drop), .learnAllow(learn), .agingEnable(age),
    .fastAging(fast), .flushCmd(cmd), .flushDone(fd));
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; waits on pready, the watchdog bounds it
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    // answer taken at the edge where pready is sampled high
    do
      @(posedge sys_clk);
    while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic frm(input logic [2:0] p, input logic [47:0] s, input logic eD, input logic eL);
    @(posedge sys_clk);
    rx <= '{1'b1, p, s};
    @(posedge sys_clk);
    rx.valid <= 1'b0;
    @(negedge sys_clk);
    chk("drop", 32'(eD), 32'(drop));
    chk("learn", 32'(eL), 32'(learn));
  endtask
  task automatic pulse;
    @(posedge sys_clk);
    fd <= 1'b1;
    @(posedge sys_clk);
    fd <= 1'b0;
  endtask
  // ====================
  // scenarios
  task automatic t_regs;
    apb(0, CTRL1_ADDR, 0);
    chk("ctrl", 32'h0000000C, r);
    chk("aging", 1, 32'(age));
    apb(1, CTRL1_ADDR, 32'h0000000A);
    repeat (2) @(negedge sys_clk);
    chk("aging", 0, 32'(age));
    chk("fast", 1, 32'(fast));
    apb(1, 32'h00000C50, 32'h000000FF);
    chk("err", 1, 32'(err));
    apb(0, 32'h00000C50, 0);
    chk("unmapped", 0, r);
    $display("t_regs done");
  endtask
  task automatic t_frames;
    apb(1, CTRL1_ADDR, 32'h000000CC);
    frm(0, MAC, 1, 0);
    frm(1, MAC, 0, 0);
    apb(1, CTRL1_ADDR, 32'h00000004);
    frm(0, MAC, 0, 1);
    frm(2, 48'h010000000001, 1, 0);
    apb(1, CTRL1_ADDR, 32'h0000000C);
    frm(2, 48'h010000000001, 0, 0);
    $display("t_frames done");
  endtask
  // three table flushes over the dynamic, static and both scopes, then one spanning-tree flush
  task automatic t_flush;
    for (int k = 0; k < 4; k++)
    begin
      apb(1, SCOPE_ADDR, 32'(k % 3 + 1));
      apb(1, CTRL1_ADDR, k < 3 ? 32'h0000002C : 32'h0000001C);
      apb(0, CTRL1_ADDR, 0);
      chk("busy", k < 3 ? 32'h0000002C : 32'h0000001C, r);
      chk("scope", 32'(k % 3 + 1), 32'({cmd.flushStatic, cmd.flushDynamic}));
      chk("mstp", 32'(k == 3), 32'(cmd.mstpOnly));
      if (k < 3)
        chk("mask", 32'h000000FF, 32'(cmd.portMask));
      pulse;
      apb(0, CTRL1_ADDR, 0);
      chk("cleared", 32'h0000000C, r);
    end
    $display("t_flush done");
  endtask
  task automatic t_link;
    link <= 7'h77;
    apb(0, STATUS_ADDR, 0);
    chk("no pending", 0, r);
    apb(1, CTRL1_ADDR, 32'h0000000D);
    link <= 7'h73;
    apb(0, CTRL1_ADDR, 0);
    chk("link mask", 32'h00000004, 32'(cmd.portMask));
    apb(0, STATUS_ADDR, 0);
    chk("pending", 32'h00000004, r);
    pulse;
    apb(0, STATUS_ADDR, 0);
    chk("pending done", 0, r);
    link <= 7'h7F;
    apb(1, CTRL1_ADDR, 32'h0000000C);
    $display("t_link done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst = 1'b1;
    req = '0;
    rx = '0;
    en = 7'h01;
    link = 7'h7F;
    fd = 1'b0;
    failures = 0;
    totalChecks = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_frames;
    t_flush;
    t_link;
    report_and_stop;
  end
  // watchdog, far beyond the hundred-odd cycles needed
  initial
  begin
    #200000;
    failures++;
    report_and_stop;
  end
endmodule // lookup_learning_aging_flush_ctrl_test
